// ### logic/mrps_params.svh
// Notes on behaviour
// - After supply crosses the monitor threshold, stay inactive a further 26 ms.
// - Both mode pins high powers up in sleep; host drives pin b low for normal.
// - Sleep to normal transition completes within 40 ms of the request.
// - Normal mode starts with two-wire port; three select-pin falls choose SPI. Wake from sleep keeps an unlocked SPI selection.
// - Lock bit 1 of secondary config locks two-wire; select toggles then ignored.
// - With SPI active, any secondary config write locks SPI until power loss or reset pin.
// - Locked port survives mode changes; only power loss or reset pin clears it.
// - Entering normal from power-up loads defaults into every register.
// - Reset-done, status b bit 15, is 0 in transition, 1 after; write-one clears.
// - Reset-done interrupt is unmaskable; line b stays low until flag cleared.
// - DSP idles after any reset until host writes 0x0001 to run register.
// - Supply below 2 V monitor threshold forces inactive state, no computation.
// - Reset pin acts only in normal mode; ignored in the other three modes.
// - Reset pin low at least 10 us plus one clock restores all defaults and raises reset-done.
// - Soft reset bit 7 restores defaults except secondary config and threshold.
// - Soft reset end clears bit 7, drives line b low, sets reset-done.
// - Soft reset only works in normal mode.
// - Phase current gain at bits 2:0, neutral gain at bits 5:3 select 1 to 16.
// - Voltage gain at bits 8:6 selects gain 1, 2, 4, 8 or 16.
`ifndef MRPS_PARAMS_SVH
`define MRPS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define MRPS_ADDR_CONFIG 4'h0
`define MRPS_ADDR_SECONDARY_CONFIG 4'h1
`define MRPS_ADDR_LOW_POWER_THRESHOLD 4'h2
`define MRPS_ADDR_STATUS_A 4'h3
`define MRPS_ADDR_STATUS_B 4'h4
`define MRPS_ADDR_INPUT_GAIN_SELECT 4'h5
`define MRPS_ADDR_RUN 4'h6

// ----------------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------------
`define MRPS_SOFT_RESET_BIT 7
`define MRPS_LOCK_BIT 1
`define MRPS_RESET_DONE_BIT 15
`define MRPS_PHASE_GAIN_LSB 0
`define MRPS_NEUTRAL_GAIN_LSB 3
`define MRPS_VOLTAGE_GAIN_LSB 6
`define MRPS_GAIN_FIELD_W 3
`define MRPS_CONFIG_RST 16'h0000
`define MRPS_SECONDARY_CONFIG_RST 16'h0000
`define MRPS_LOW_POWER_THRESHOLD_RST 16'h0000
`define MRPS_GAIN_RST 16'h0000
`define MRPS_RUN_RST 16'h0000
`define MRPS_RUN_START 16'h0001

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MRPS_CLK_HZ 10000000
`define MRPS_HOLDOFF_MS 26
`define MRPS_HOLDOFF_CYC (`MRPS_HOLDOFF_MS * `MRPS_CLK_HZ / 1000)
`define MRPS_WAKE_MAX_MS 40
`define MRPS_WAKE_CYC (`MRPS_WAKE_MAX_MS * `MRPS_CLK_HZ / 1000)
`define MRPS_RESET_LOW_US 10
`define MRPS_RESET_LOW_CYC ((`MRPS_RESET_LOW_US * `MRPS_CLK_HZ + 999999) / 1000000)
`define MRPS_XFER_CYC 16

`endif

// ### logic/mrps_pkg.sv
package mrps_pkg;

    // One-hot sequencer states.
    typedef enum logic [6:0] {
        ST_INACTIVE = 7'h01,
        ST_HOLDOFF = 7'h02,
        ST_SLEEP = 7'h04,
        ST_WAKE = 7'h08,
        ST_NORMAL = 7'h10,
        ST_HWHOLD = 7'h20,
        ST_XFER = 7'h40
    } mrps_state_type;

    typedef enum logic [1:0] {
        NORMAL_POWER_MODE = 2'h0,
        REDUCED_POWER_MODE = 2'h1,
        LOW_POWER_MODE = 2'h2,
        SLEEP_POWER_MODE = 2'h3
    } mrps_mode_type;

    typedef struct packed {
        logic modeSelectPinA;
        logic modeSelectPinB;
        logic resetPinN;
        logic slaveSelectPin;
    } mrps_pins_type;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [3:0] addr;
        logic [15:0] wrData;
    } mrps_req_type;

    typedef struct packed {
        logic [4:0] phaseCurrentGain;
        logic [4:0] neutralCurrentGain;
        logic [4:0] voltageGain;
    } mrps_gains_type;

endpackage

// ### logic/mrps_gain_decode.sv
`timescale 1ns/1ns
module mrps_gain_decode
    import mrps_pkg::*;
(
    // Field code in, multiplier out
    input wire logic [2:0] code,
    output logic [4:0] gain
);

    always_comb begin
        case (code)
            3'h0: gain = 5'h01;
            3'h1: gain = 5'h02;
            3'h2: gain = 5'h04;
            3'h3: gain = 5'h08;
            3'h4: gain = 5'h10;
            default: gain = 5'h01;
        endcase
    end

endmodule

// ### logic/mrps_seq.sv
`timescale 1ns/1ns
`include "mrps_params.svh"
module mrps_seq
    import mrps_pkg::*;
#(
    parameter int HOLDOFF_CYCLES = `MRPS_HOLDOFF_CYC,
    parameter int WAKE_CYCLES = `MRPS_WAKE_CYC,
    parameter int RESET_LOW_CYCLES = `MRPS_RESET_LOW_CYC,
    parameter int XFER_CYCLES = `MRPS_XFER_CYC
)
(
    // Clock and power-on reset
    input wire logic mclk,
    input wire logic rst,
    // Supply monitor, high while supply is above threshold
    input wire logic supplyOk,
    // Host pins
    input wire mrps_pins_type pins,
    // Register access from the serial port front end
    input wire mrps_req_type req,
    output logic [15:0] regRdData,
    // Status and control towards the rest of the chip
    output logic interruptLineBN,
    output logic dspRun,
    output logic spiActive,
    output logic portLocked,
    output mrps_mode_type powerMode,
    output logic inNormal,
    output mrps_gains_type gains
);

    localparam int CNT_W = 20;
    if (HOLDOFF_CYCLES < 1 || HOLDOFF_CYCLES >= (1 << CNT_W) ||
        WAKE_CYCLES < 2 || WAKE_CYCLES >= (1 << CNT_W) ||
        RESET_LOW_CYCLES < 1 || RESET_LOW_CYCLES >= (1 << CNT_W) ||
        XFER_CYCLES < 1 || XFER_CYCLES >= (1 << CNT_W)) begin : gen_bad_timing
        $error("mrps_seq: timing parameter out of range");
    end
    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    mrps_state_type state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [15:0] configReg, next_configReg;
    logic [15:0] secondaryConfigReg, next_secondaryConfigReg;
    logic [15:0] lowPowerThresholdReg, next_lowPowerThresholdReg;
    logic [15:0] inputGainSelect, next_inputGainSelect;
    logic [15:0] runReg, next_runReg;
    logic resetDoneFlag, next_resetDoneFlag;
    logic next_spiActive, next_portLocked;
    logic selPrev, next_selPrev;
    logic [1:0] selFalls, next_selFalls;
    logic powerUpPending, next_powerUpPending;
    logic softXfer, next_softXfer;
    logic [15:0] next_regRdData;
    logic next_dspRun;
    logic regWrite, selFall, loadSoft, loadFull;
    mrps_mode_type pinMode;

    // Mode pins a and b: both high is sleep, b low with a high is normal.
    always_comb begin
        case ({pins.modeSelectPinA, pins.modeSelectPinB})
            2'b11: pinMode = SLEEP_POWER_MODE;
            2'b10: pinMode = NORMAL_POWER_MODE;
            2'b01: pinMode = REDUCED_POWER_MODE;
            default: pinMode = LOW_POWER_MODE;
        endcase
    end

    // ------------------------------------------------------------------------
    // Sequencer and register file
    // ------------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_configReg = configReg;
        next_secondaryConfigReg = secondaryConfigReg;
        next_lowPowerThresholdReg = lowPowerThresholdReg;
        next_inputGainSelect = inputGainSelect;
        next_runReg = runReg;
        next_resetDoneFlag = resetDoneFlag;
        next_spiActive = spiActive;
        next_portLocked = portLocked;
        next_selPrev = pins.slaveSelectPin;
        next_selFalls = selFalls;
        next_powerUpPending = powerUpPending;
        next_softXfer = softXfer;
        loadSoft = 1'b0;
        loadFull = 1'b0;
        regWrite = (state == ST_NORMAL) && req.wrEn;
        selFall = selPrev && !pins.slaveSelectPin;
        case (state)
            ST_INACTIVE: begin
                if (supplyOk) begin
                    next_state = ST_HOLDOFF;
                    next_cnt = '0;
                end
            end
            ST_HOLDOFF: begin
                if (cnt == CNT_W'(HOLDOFF_CYCLES - 1)) begin
                    next_state = ST_SLEEP;
                    next_cnt = '0;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            ST_SLEEP: begin
                if (pinMode == NORMAL_POWER_MODE) begin
                    next_state = ST_WAKE;
                    next_cnt = '0;
                    next_resetDoneFlag = 1'b0;
                end
            end
            ST_WAKE: begin
                if (pinMode != NORMAL_POWER_MODE) begin
                    next_state = ST_SLEEP;
                end else if (cnt == CNT_W'(WAKE_CYCLES - 2)) begin
                    next_state = ST_NORMAL;
                    next_resetDoneFlag = 1'b1;
                    loadFull = powerUpPending;
                    next_powerUpPending = 1'b0;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            ST_NORMAL: begin
                if (pinMode != NORMAL_POWER_MODE) begin
                    next_state = ST_SLEEP;
                end else if (!pins.resetPinN) begin
                    next_state = ST_HWHOLD;
                    next_cnt = '0;
                end else begin
                    if (!portLocked && !spiActive && selFall) begin
                        next_selFalls = selFalls + 1'b1;
                        if (selFalls == 2'h2) begin
                            next_spiActive = 1'b1;
                        end
                    end
                    if (regWrite) begin
                        case (req.addr)
                            `MRPS_ADDR_CONFIG: begin
                                next_configReg = req.wrData;
                                if (req.wrData[`MRPS_SOFT_RESET_BIT]) begin
                                    next_state = ST_XFER;
                                    next_cnt = '0;
                                    next_softXfer = 1'b1;
                                    next_resetDoneFlag = 1'b0;
                                end
                            end
                            `MRPS_ADDR_SECONDARY_CONFIG: begin
                                next_secondaryConfigReg = req.wrData;
                                if (spiActive || req.wrData[`MRPS_LOCK_BIT]) begin
                                    next_portLocked = 1'b1;
                                end
                            end
                            `MRPS_ADDR_LOW_POWER_THRESHOLD: next_lowPowerThresholdReg = req.wrData;
                            `MRPS_ADDR_STATUS_B: begin
                                if (req.wrData[`MRPS_RESET_DONE_BIT]) begin
                                    next_resetDoneFlag = 1'b0;
                                end
                            end
                            `MRPS_ADDR_INPUT_GAIN_SELECT: next_inputGainSelect = req.wrData;
                            `MRPS_ADDR_RUN: next_runReg = req.wrData;
                            default: ;
                        endcase
                    end
                end
            end
            ST_HWHOLD: begin
                if (pinMode != NORMAL_POWER_MODE) begin
                    next_state = ST_SLEEP;
                end else if (pins.resetPinN) begin
                    if (cnt >= CNT_W'(RESET_LOW_CYCLES)) begin
                        next_state = ST_XFER;
                        next_cnt = '0;
                        next_softXfer = 1'b0;
                        next_resetDoneFlag = 1'b0;
                    end else begin
                        next_state = ST_NORMAL;
                    end
                end else if (cnt != CNT_W'(RESET_LOW_CYCLES)) begin
                    next_cnt = cnt + 1'b1;
                end
            end
            ST_XFER: begin
                if (cnt == CNT_W'(XFER_CYCLES - 1)) begin
                    next_state = ST_NORMAL;
                    next_resetDoneFlag = 1'b1;
                    loadSoft = softXfer;
                    loadFull = !softXfer;
                end else begin
                    next_cnt = cnt + 1'b1;
                end
            end
            default: next_state = ST_INACTIVE;
        endcase
        if (loadSoft || loadFull) begin
            next_configReg = `MRPS_CONFIG_RST;
            next_inputGainSelect = `MRPS_GAIN_RST;
            next_runReg = `MRPS_RUN_RST;
            if (loadFull || !portLocked) begin
                next_spiActive = 1'b0;
                next_selFalls = 2'h0;
            end
        end
        if (loadFull) begin
            next_secondaryConfigReg = `MRPS_SECONDARY_CONFIG_RST;
            next_lowPowerThresholdReg = `MRPS_LOW_POWER_THRESHOLD_RST;
            next_portLocked = 1'b0;
        end
        if (!supplyOk) begin
            next_state = ST_INACTIVE;
            next_cnt = '0;
            next_powerUpPending = 1'b1;
            next_resetDoneFlag = 1'b0;
            next_portLocked = 1'b0;
            next_spiActive = 1'b0;
            next_selFalls = 2'h0;
            next_runReg = `MRPS_RUN_RST;
        end
    end

    // Read data and DSP run state are registered.
    always_comb begin
        next_regRdData = regRdData;
        if (req.rdEn) begin
            case (req.addr)
                `MRPS_ADDR_CONFIG: next_regRdData = configReg;
                `MRPS_ADDR_SECONDARY_CONFIG: next_regRdData = secondaryConfigReg;
                `MRPS_ADDR_LOW_POWER_THRESHOLD: next_regRdData = lowPowerThresholdReg;
                `MRPS_ADDR_STATUS_B: next_regRdData = {resetDoneFlag, 15'h0000};
                `MRPS_ADDR_INPUT_GAIN_SELECT: next_regRdData = inputGainSelect;
                `MRPS_ADDR_RUN: next_regRdData = runReg;
                default: next_regRdData = 16'h0000;
            endcase
        end
        next_dspRun = (next_state == ST_NORMAL) && (next_runReg == `MRPS_RUN_START);
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ST_INACTIVE;
            cnt <= '0;
            configReg <= `MRPS_CONFIG_RST;
            secondaryConfigReg <= `MRPS_SECONDARY_CONFIG_RST;
            lowPowerThresholdReg <= `MRPS_LOW_POWER_THRESHOLD_RST;
            inputGainSelect <= `MRPS_GAIN_RST;
            runReg <= `MRPS_RUN_RST;
            resetDoneFlag <= 1'b0;
            spiActive <= 1'b0;
            portLocked <= 1'b0;
            selPrev <= 1'b1;
            selFalls <= 2'h0;
            powerUpPending <= 1'b1;
            softXfer <= 1'b0;
            regRdData <= 16'h0000;
            dspRun <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            configReg <= next_configReg;
            secondaryConfigReg <= next_secondaryConfigReg;
            lowPowerThresholdReg <= next_lowPowerThresholdReg;
            inputGainSelect <= next_inputGainSelect;
            runReg <= next_runReg;
            resetDoneFlag <= next_resetDoneFlag;
            spiActive <= next_spiActive;
            portLocked <= next_portLocked;
            selPrev <= next_selPrev;
            selFalls <= next_selFalls;
            powerUpPending <= next_powerUpPending;
            softXfer <= next_softXfer;
            regRdData <= next_regRdData;
            dspRun <= next_dspRun;
        end
    end

    // The reset-done interrupt has no mask.
    assign interruptLineBN = !resetDoneFlag;
    assign inNormal = (state == ST_NORMAL);
    assign powerMode = pinMode;

    // ------------------------------------------------------------------------
    // Gain field decode
    // ------------------------------------------------------------------------
    logic [4:0] gainVec [0:2];
    for (genvar g = 0; g < 3; g++) begin : gen_gain
        mrps_gain_decode u_dec (
            .code(inputGainSelect[g*`MRPS_GAIN_FIELD_W +: `MRPS_GAIN_FIELD_W]),
            .gain(gainVec[g])
        );
    end
    assign gains.phaseCurrentGain = gainVec[0];
    assign gains.neutralCurrentGain = gainVec[1];
    assign gains.voltageGain = gainVec[2];

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_holdoff_len:
        assert property ((state == ST_HOLDOFF) && $past(state) == ST_INACTIVE && supplyOk
            |-> cnt == '0)
        else $error("hold-off did not start from zero");
    a_holdoff_exit:
        assert property ($past(state) == ST_HOLDOFF && state == ST_SLEEP
            |-> $past(cnt) == CNT_W'(HOLDOFF_CYCLES - 1))
        else $error("hold-off left early");
    a_wake_bound:
        assert property ((state == ST_WAKE) |-> cnt <= CNT_W'(WAKE_CYCLES - 2))
        else $error("wake transition overran");
    a_powerup_defaults:
        assert property (state == ST_WAKE && next_state == ST_NORMAL && powerUpPending && supplyOk
            |=> !spiActive && !portLocked && secondaryConfigReg == `MRPS_SECONDARY_CONFIG_RST)
        else $error("power-up defaults not loaded");
    a_lock_twowire:
        assert property (portLocked && !spiActive && state == ST_NORMAL && supplyOk
            |=> !spiActive)
        else $error("locked two-wire port switched");
    a_spi_lock:
        assert property (regWrite && spiActive && pins.resetPinN && supplyOk
            && pinMode == NORMAL_POWER_MODE && req.addr == `MRPS_ADDR_SECONDARY_CONFIG |=> portLocked)
        else $error("SPI not locked by secondary config write");
    a_done_holds:
        assert property (resetDoneFlag && !regWrite && supplyOk && next_state != ST_WAKE
            && next_state != ST_XFER |=> resetDoneFlag)
        else $error("reset-done dropped without host clear");
    a_pin_ignored:
        assert property (state != ST_NORMAL && state != ST_HWHOLD |=> state != ST_HWHOLD)
        else $error("reset pin acted outside normal mode");
    a_soft_end:
        assert property (state == ST_XFER && next_state == ST_NORMAL && supplyOk
            |=> resetDoneFlag && !configReg[`MRPS_SOFT_RESET_BIT] && !interruptLineBN)
        else $error("soft reset end not signalled");
    a_supply_drop:
        assert property (!supplyOk |=> state == ST_INACTIVE && !dspRun)
        else $error("device active with supply low");

endmodule

// ### bench/mrps_host_model.sv
`timescale 1ns/1ns
module mrps_host_model
    import mrps_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Pins and register requests towards the device
    output mrps_pins_type pins,
    output mrps_req_type req
);
    initial begin
        pins = 4'hf;
        req = '0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        step(1);
        req = '{1'b1, 1'b0, a, d};
        step(1);
        req = '0;
    endtask
    task automatic rd(input logic [3:0] a);
        step(1);
        req = '{1'b0, 1'b1, a, 16'h0000};
        step(1);
        req = '0;
    endtask
    task automatic mode(input logic a, input logic b);
        step(1);
        pins.modeSelectPinA = a;
        pins.modeSelectPinB = b;
    endtask
    // The pin is held low for n whole cycles before it is released.
    task automatic pulseReset(input int n);
        step(1);
        pins.resetPinN = 1'b0;
        step(n);
        pins.resetPinN = 1'b1;
    endtask
    task automatic toggleSelect(input int n);
        repeat (n) begin
            step(1);
            pins.slaveSelectPin = 1'b0;
            step(1);
            pins.slaveSelectPin = 1'b1;
        end
    endtask
    // Random pins and writes for modes in which the device must ignore them.
    task automatic noise(input logic [31:0] r);
        step(1);
        pins = '{r[0], 1'b1, r[1], r[2]};
        req = '{r[3], 1'b0, r[7:4], r[23:8]};
    endtask
endmodule

// ### bench/meter_reset_port_select_seq_test.sv
`timescale 1ns/1ns
module meter_reset_port_select_seq_test;
    import mrps_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic supplyOk = 1'b0;
    logic rdFlag = 1'b0;
    logic [15:0] regRdData;
    logic interruptLineBN, dspRun, spiActive, portLocked, inNormal;
    logic [31:0] seed = 32'h109ccb4d;
    logic [15:0] v;
    mrps_mode_type powerMode;
    mrps_gains_type gains;
    mrps_pins_type pins;
    mrps_req_type req;
    int badCount = 0;
    int nChecks = 0;
    logic [15:0] expQ[$];
    always #50 mclk = ~mclk;
    mrps_host_model host (.mclk(mclk), .pins(pins), .req(req));
    mrps_seq #(.HOLDOFF_CYCLES(20), .WAKE_CYCLES(10), .RESET_LOW_CYCLES(4),
        .XFER_CYCLES(4)) uut (.mclk(mclk), .rst(rst), .supplyOk(supplyOk), .pins(pins),
        .req(req), .regRdData(regRdData), .interruptLineBN(interruptLineBN),
        .dspRun(dspRun), .spiActive(spiActive), .portLocked(portLocked),
        .powerMode(powerMode), .inNormal(inNormal), .gains(gains));
    // ------------------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp) begin
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
            badCount++;
        end
    endtask
    // Read data lands one cycle after the strobe and is judged at mid-cycle.
    always @(negedge mclk) begin
        if (rdFlag) chk(regRdData, expQ.pop_front());
        rdFlag = req.rdEn;
    end
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        expQ.push_back(e);
        host.rd(a);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic waitNormal(input int lim);
        for (int k = 0; k < lim && inNormal !== 1'b1; k++) cyc(1);
        chk(16'(inNormal), 16'h0001);
    endtask
    function automatic logic [4:0] gx(input logic [2:0] c);
        return (c < 3'h5) ? 5'h01 << c : 5'h01;
    endfunction
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic endSim();
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        badCount++;
        endSim();
    end
    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge mclk);
        #1;
        rst = 1'b0;
        supplyOk = 1'b1;
        cyc(18);
        chk(16'(inNormal), 16'h0000);
        cyc(12);
        chk(16'(powerMode), 16'h0003);
        host.mode(1'b1, 1'b0);
        cyc(8);
        chk(16'(inNormal), 16'h0000);
        waitNormal(4);
        chk(16'(interruptLineBN), 16'h0000);
        rd(4'h4, 16'h8000);
        rd(4'h1, 16'h0000);
        rd(4'h2, 16'h0000);
        host.wr(4'h4, 16'hffff);
        host.wr(4'h3, 16'hffff);
        cyc(1);
        chk(16'(interruptLineBN), 16'h0001);
        $display("power-up done");
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            v = {7'h00, seed[2:0], seed[5:3], 3'(i)};
            host.wr(4'h5, v);
            cyc(1);
            chk(16'(gains), {1'b0, gx(v[2:0]), gx(v[5:3]), gx(v[8:6])});
            rd(4'h5, v);
        end
        $display("gain done");
        host.toggleSelect(3);
        cyc(1);
        chk(16'(spiActive), 16'h0001);
        host.pulseReset(2);
        cyc(3);
        chk(16'(spiActive), 16'h0001);
        host.wr(4'h1, 16'h0004);
        cyc(1);
        chk(16'(portLocked), 16'h0001);
        host.wr(4'h2, v);
        host.wr(4'h0, 16'h0080);
        cyc(1);
        rd(4'h4, 16'h0000);
        waitNormal(10);
        chk(16'(interruptLineBN), 16'h0000);
        rd(4'h0, 16'h0000);
        rd(4'h5, 16'h0000);
        rd(4'h1, 16'h0004);
        rd(4'h2, v);
        chk(16'({spiActive, portLocked}), 16'h0003);
        host.wr(4'h4, 16'hffff);
        $display("soft reset done");
        host.pulseReset(5);
        cyc(2);
        waitNormal(10);
        chk(16'({spiActive, portLocked}), 16'h0000);
        rd(4'h1, 16'h0000);
        rd(4'h2, 16'h0000);
        rd(4'h4, 16'h8000);
        host.wr(4'h4, 16'hffff);
        $display("hardware reset done");
        host.wr(4'h1, 16'h0002);
        host.toggleSelect(3);
        cyc(1);
        chk(16'({spiActive, portLocked}), 16'h0001);
        host.mode(1'b0, 1'b1);
        cyc(2);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            host.noise(seed);
            cyc(1);
            chk(16'(powerMode), seed[0] ? 16'h0003 : 16'h0001);
            chk(16'({inNormal, portLocked}), 16'h0001);
        end
        host.noise(32'h00000007);
        host.pulseReset(5);
        host.wr(4'h0, 16'h0080);
        host.mode(1'b1, 1'b0);
        cyc(2);
        waitNormal(12);
        chk(16'(portLocked), 16'h0001);
        rd(4'h0, 16'h0000);
        $display("mode change done");
        host.wr(4'h6, 16'h0001);
        cyc(1);
        chk(16'(dspRun), 16'h0001);
        supplyOk = 1'b0;
        cyc(1);
        chk(16'({inNormal, dspRun}), 16'h0000);
        $display("supply loss done");
        cyc(2);
        endSim();
    end
endmodule
